/* File: logic/rmpi_defines.svh */
`ifndef RMPI_DEFINES_SVH
`define RMPI_DEFINES_SVH

// ==========================================================================
// line rates and the dibit slot divider derived from them
`define RMPI_RATE_100_MBPS 100
`define RMPI_RATE_10_MBPS  10
`define RMPI_DIV_10M       (`RMPI_RATE_100_MBPS / `RMPI_RATE_10_MBPS)

// ==========================================================================
// receive path sizes
`define RMPI_FIFO_DEPTH    32
`define RMPI_CD_WINDOW     10

// ==========================================================================
// fixed dibit values
`define RMPI_DIBIT_ZERO    2'h0

`endif

/* File: logic/rmpi_if.sv */
`timescale 1ns/1ps

// ==========================================================================
// reduced media independent link between transceiver and mac
interface rmpi_if;
    logic                  ref_clk;
    logic                  txen;
    rmpi_pkg::rmpi_dibit_t txd;
    rmpi_pkg::rmpi_dibit_t rxd;
    logic                  crs_dv;
    logic                  rxer;

    modport phy_mp (
        input  ref_clk,
        input  txen,
        input  txd,
        output rxd,
        output crs_dv,
        output rxer
    );

    modport mac_mp (
        input  ref_clk,
        input  rxd,
        input  crs_dv,
        input  rxer,
        output txen,
        output txd
    );
endinterface

/* File: logic/rmpi_mac_end.sv */
`timescale 1ns/1ps
`include "rmpi_defines.svh"

module rmpi_mac_end #(
    parameter int DIV_10M = `RMPI_DIV_10M
) (
    input  wire logic                  clock_i,
    input  wire logic                  rst_b_i,
    rmpi_if.mac_mp                     link,
    input  wire logic                  speed_100_i,
    input  wire logic                  full_duplex_i,
    input  wire logic                  tx_valid_i,
    input  rmpi_pkg::rmpi_nibble_t     tx_nibble_i,
    output logic                       tx_ready_o,
    output rmpi_pkg::rmpi_nibble_t     rx_nibble_o,
    output logic                       rx_nibble_stb_o,
    output logic                       rx_frame_o,
    output logic                       crs_o,
    output logic                       col_o
);
    import rmpi_pkg::*;

    localparam logic [3:0] DIV_LAST = 4'(DIV_10M - 1);

    // ==========================================================================
    // link input synchronisers, receive error left unused on purpose

    logic        ref_s1, ref_s2, ref_s3;
    logic        crs_s1, crs_s2;
    rmpi_dibit_t rxd_s1, rxd_s2;
    logic        ref_rise;

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
            crs_s1 <= 1'b0;
            crs_s2 <= 1'b0;
            rxd_s1 <= `RMPI_DIBIT_ZERO;
            rxd_s2 <= `RMPI_DIBIT_ZERO;
        end else begin
            ref_s1 <= link.ref_clk;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
            crs_s1 <= link.crs_dv;
            crs_s2 <= crs_s1;
            rxd_s1 <= link.rxd;
            rxd_s2 <= rxd_s1;
        end
    end

    assign ref_rise = ref_s2 & ~ref_s3;

    // ==========================================================================
    // transmit

    logic        txen_q, hi_pend;
    rmpi_dibit_t txd_q, hi_q;
    logic [3:0]  tx_div;
    logic        tx_slot;

    // ten reference cycles per dibit at 10 Mbps
    assign tx_slot    = ref_rise & (speed_100_i | ~txen_q | (tx_div == DIV_LAST));
    assign tx_ready_o = tx_slot & ~hi_pend;

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            tx_div <= 4'h0;
        end else if (ref_rise) begin
            tx_div <= (!txen_q || tx_div == DIV_LAST) ? 4'h0 : tx_div + 4'h1;
        end
    end

    // changed on reference edges, low dibit first
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            txen_q  <= 1'b0;
            txd_q   <= `RMPI_DIBIT_ZERO;
            hi_q    <= `RMPI_DIBIT_ZERO;
            hi_pend <= 1'b0;
        end else if (tx_slot) begin
            if (hi_pend) begin
                txd_q   <= hi_q;
                hi_pend <= 1'b0;
            end else if (tx_valid_i) begin
                txen_q  <= 1'b1;
                txd_q   <= tx_nibble_i[1:0];
                hi_q    <= tx_nibble_i[3:2];
                hi_pend <= 1'b1;
            end else begin
                txen_q <= 1'b0;
                txd_q  <= `RMPI_DIBIT_ZERO;
            end
        end
    end

    assign link.txen = txen_q;
    assign link.txd  = txd_q;

    // ==========================================================================
    // receive

    logic        second, lo_dv;
    rmpi_dibit_t lo_q;
    logic [3:0]  rx_div;
    logic        rx_take;

    // data counts from crs_dv, first non-zero dibit starts it
    assign rx_take = ref_rise & (rx_frame_o ? (speed_100_i | rx_div == DIV_LAST)
                                            : (crs_s2 & rxd_s2 != `RMPI_DIBIT_ZERO));

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            rx_div <= 4'h0;
        end else if (ref_rise) begin
            rx_div <= (!rx_frame_o || rx_div == DIV_LAST) ? 4'h0 : rx_div + 4'h1;
        end
    end

    // a nibble is data if crs_dv was high on either half
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            rx_frame_o      <= 1'b0;
            second          <= 1'b0;
            lo_dv           <= 1'b0;
            lo_q            <= `RMPI_DIBIT_ZERO;
            rx_nibble_o     <= 4'h0;
            rx_nibble_stb_o <= 1'b0;
        end else begin
            rx_nibble_stb_o <= 1'b0;
            if (rx_take) begin
                rx_frame_o <= 1'b1;
                second     <= ~second;
                if (!second) begin
                    lo_q  <= rxd_s2;
                    lo_dv <= crs_s2;
                end else if (crs_s2 || lo_dv) begin
                    rx_nibble_o     <= {rxd_s2, lo_q};
                    rx_nibble_stb_o <= 1'b1;
                end else begin
                    rx_frame_o <= 1'b0;
                end
            end
        end
    end

    // carrier read on first dibits inside a frame
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            crs_o <= 1'b0;
            col_o <= 1'b0;
        end else begin
            if (ref_rise && (!rx_frame_o || (rx_take && !second))) begin
                crs_o <= crs_s2;
            end
            col_o <= ~full_duplex_i & txen_q & crs_o;
        end
    end

endmodule

/* File: logic/rmpi_phy_end.sv */
// Notes on behaviour
// - autoneg off: force speed, duplex from bits
// - autoneg on: use negotiated speed, duplex
// - half duplex: carrier sense on tx or rx
// - half duplex: rx during tx is collision
// - full duplex: carrier sense only on rx
// - full duplex: no collision, simultaneous tx/rx
// - link runs at 10 or 100 Mbps
// - one reference clock times both paths
// - independent two-bit tx and rx paths
// - raise crs_dv at once on carrier
// - carrier: squelch, or gapped zeros in ten
// - drop crs_dv only on first dibit
// - leftover bits: crs_dv toggles per nibble half
// - toggle runs at the nibble rate
// - false carrier holds crs_dv while active
// - mac takes rxd valid from crs_dv
// - rxd reads 00 until decoding starts
// - continuous reference clock times all link pins (a rising crs_dv here is set at once, not on a reference edge)
// - tx uses reference clock, no buffering
// - rx crosses an elasticity buffer
// - rx error optional, mac copes without
// - rx dibits valid at reference rising edge
`timescale 1ns/1ps
`include "rmpi_defines.svh"

module rmpi_phy_end #(
    parameter int FIFO_DEPTH = `RMPI_FIFO_DEPTH,
    parameter int DIV_10M    = `RMPI_DIV_10M
) (
    input  wire logic                  clock_i,
    input  wire logic                  rst_b_i,
    rmpi_if.phy_mp                     link,
    input  wire logic                  an_enable_i,
    input  wire logic                  force_speed_100_i,
    input  wire logic                  force_full_duplex_i,
    input  wire logic                  an_speed_100_i,
    input  wire logic                  an_full_duplex_i,
    input  wire logic                  squelch_pass_i,
    input  wire logic                  code_bit_i,
    input  wire logic                  code_stb_i,
    input  wire logic                  data_bit_i,
    input  wire logic                  data_stb_i,
    input  wire logic                  rx_err_i,
    output logic                       speed_100_o,
    output logic                       full_duplex_o,
    output logic                       carrier_sense_o,
    output logic                       collision_o,
    output logic                       line_tx_en_o,
    output rmpi_pkg::rmpi_dibit_t      line_tx_dibit_o,
    output logic                       line_tx_stb_o
);
    import rmpi_pkg::*;

    localparam int       AW       = $clog2(FIFO_DEPTH);
    localparam int       CDW      = `RMPI_CD_WINDOW;
    localparam logic [3:0] DIV_LAST = 4'(DIV_10M - 1);
    localparam logic [AW:0] FULL_FILL = (AW + 1)'(FIFO_DEPTH);

    // ==========================================================================
    // helpers

    // two zeros with at least one bit between them inside the window
    function automatic logic gap_zeros(input logic [CDW-1:0] w);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < CDW; i++) begin
            for (int j = i + 2; j < CDW; j++) begin
                if (!w[i] && !w[j]) begin
                    hit = 1'b1;
                end
            end
        end
        return hit;
    endfunction

    // ==========================================================================
    // mode resolution

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            speed_100_o   <= 1'b1;
            full_duplex_o <= 1'b0;
        end else if (an_enable_i) begin
            speed_100_o   <= an_speed_100_i;
            full_duplex_o <= an_full_duplex_i;
        end else begin
            speed_100_o   <= force_speed_100_i;
            full_duplex_o <= force_full_duplex_i;
        end
    end

    // ==========================================================================
    // link input synchronisers

    logic        ref_s1, ref_s2, ref_s3;
    logic        txen_s1, txen_s2;
    rmpi_dibit_t txd_s1, txd_s2;
    logic        ref_rise;

    // one sampled reference clock for both paths
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            ref_s1  <= 1'b0;
            ref_s2  <= 1'b0;
            ref_s3  <= 1'b0;
            txen_s1 <= 1'b0;
            txen_s2 <= 1'b0;
            txd_s1  <= `RMPI_DIBIT_ZERO;
            txd_s2  <= `RMPI_DIBIT_ZERO;
        end else begin
            ref_s1  <= link.ref_clk;
            ref_s2  <= ref_s1;
            ref_s3  <= ref_s2;
            txen_s1 <= link.txen;
            txen_s2 <= txen_s1;
            txd_s1  <= link.txd;
            txd_s2  <= txd_s1;
        end
    end

    // every link pin but a rising crs_dv moves on reference rising edges
    assign ref_rise = ref_s2 & ~ref_s3;

    // ==========================================================================
    // dibit slot timing

    logic [3:0] rx_div;
    logic [3:0] tx_div;
    logic       rx_slot;
    logic       tx_take;

    // ten reference cycles per dibit at 10 Mbps
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            rx_div <= 4'h0;
        end else if (ref_rise) begin
            rx_div <= (rx_div == DIV_LAST) ? 4'h0 : rx_div + 4'h1;
        end
    end

    // tx slot counter realigns to the start of each transmit burst
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            tx_div <= 4'h0;
        end else if (ref_rise) begin
            if (!txen_s2) begin
                tx_div <= 4'h0;
            end else begin
                tx_div <= (tx_div == DIV_LAST) ? 4'h0 : tx_div + 4'h1;
            end
        end
    end

    // slot rate follows the resolved speed
    assign rx_slot = ref_rise & (speed_100_o | (rx_div == 4'h0));
    assign tx_take = ref_rise & txen_s2 & (speed_100_o | (tx_div == 4'h0));

    // ==========================================================================
    // transmit path

    // straight to the line on the reference clock
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            line_tx_en_o    <= 1'b0;
            line_tx_dibit_o <= `RMPI_DIBIT_ZERO;
            line_tx_stb_o   <= 1'b0;
        end else begin
            line_tx_stb_o <= tx_take;
            if (ref_rise) begin
                line_tx_en_o <= txen_s2;
            end
            if (tx_take) begin
                line_tx_dibit_o <= txd_s2;
            end
        end
    end

    // ==========================================================================
    // carrier detection

    logic [CDW-1:0] cd_win;
    logic           carrier_100;
    logic           carrier;

    // window idles at all ones
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            cd_win      <= {CDW{1'b1}};
            carrier_100 <= 1'b0;
        end else if (code_stb_i) begin
            cd_win <= {cd_win[CDW-2:0], code_bit_i};
            // gapped zeros start it, all ones end it
            if (gap_zeros({cd_win[CDW-2:0], code_bit_i})) begin
                carrier_100 <= 1'b1;
            end else if (&{cd_win[CDW-2:0], code_bit_i}) begin
                carrier_100 <= 1'b0;
            end
        end
    end

    assign carrier = speed_100_o ? carrier_100 : squelch_pass_i;

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            carrier_sense_o <= 1'b0;
            collision_o     <= 1'b0;
        end else begin
            carrier_sense_o <= carrier | (~full_duplex_o & txen_s2);
            collision_o     <= ~full_duplex_o & txen_s2 & carrier;
        end
    end

    // ==========================================================================
    // receive elasticity buffer

    rmpi_rx_state_t rx_state;
    logic           fifo_mem [FIFO_DEPTH];
    logic [AW-1:0]  wr_ptr, rd_ptr;
    logic [AW:0]    fill;
    logic           push, pop;

    // decoded bits cross into reference timing here
    assign push = data_stb_i & (rx_state != rx_idle) & (fill < FULL_FILL);
    assign pop  = rx_slot & (rx_state != rx_idle) & (fill >= (AW + 1)'(2));

    always_ff @(posedge clock_i) begin
        if (push) begin
            fifo_mem[wr_ptr] <= data_bit_i;
        end
    end

    // flushed whenever the receiver is idle
    always_ff @(posedge clock_i) begin
        if (!rst_b_i || rx_state == rx_idle) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= AW'(rd_ptr + 2'h2);
            end
            case ({push, pop})
                2'b10:   fill <= (AW + 1)'(fill + 1'b1);
                2'b01:   fill <= (AW + 1)'(fill - 2'h2);
                2'b11:   fill <= (AW + 1)'(fill - 1'b1);
                default: fill <= fill;
            endcase
        end
    end

    // ==========================================================================
    // receive sequencer and link outputs

    logic        phase;
    rmpi_dibit_t rxd_q;
    logic        crs_dv_q;
    logic        rxer_q;

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            rx_state <= rx_idle;
            phase    <= 1'b0;
            rxd_q    <= `RMPI_DIBIT_ZERO;
            crs_dv_q <= 1'b0;
        end else begin
            case (rx_state)
                rx_idle: begin
                    // no wait for a reference edge
                    if (carrier) begin
                        rx_state <= rx_carrier;
                        crs_dv_q <= 1'b1;
                        phase    <= 1'b0;
                        rxd_q    <= `RMPI_DIBIT_ZERO;
                    end
                end
                rx_carrier, rx_drain: begin
                    if (rx_state == rx_carrier && !carrier) begin
                        rx_state <= rx_drain;
                    end
                    if (pop) begin
                        // low bit first, set on a reference edge
                        rxd_q <= {fifo_mem[AW'(rd_ptr + 1'b1)], fifo_mem[rd_ptr]};
                        phase <= ~phase;
                        // without carrier, low on first, high on second dibit
                        crs_dv_q <= (carrier & (rx_state == rx_carrier)) | phase;
                    end else if (rx_slot) begin
                        // zeros until decoded bits are ready
                        rxd_q <= `RMPI_DIBIT_ZERO;
                        if (!(carrier && rx_state == rx_carrier) && !phase) begin
                            rx_state <= rx_idle;
                            crs_dv_q <= 1'b0;
                        end else begin
                            phase <= 1'b0;
                        end
                    end
                end
                default: begin
                    rx_state <= rx_idle;
                    crs_dv_q <= 1'b0;
                end
            endcase
        end
    end

    // error flag per dibit, only inside a receive event
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            rxer_q <= 1'b0;
        end else if (rx_slot) begin
            rxer_q <= rx_err_i & (rx_state != rx_idle);
        end
    end

    assign link.rxd    = rxd_q;
    assign link.crs_dv = crs_dv_q;
    assign link.rxer   = rxer_q;

endmodule

/* File: logic/rmpi_pkg.sv */
package rmpi_pkg;

    // ==========================================================================
    // shared types
    typedef logic [1:0] rmpi_dibit_t;
    typedef logic [3:0] rmpi_nibble_t;

    // receive sequencer, gray coded along idle -> carrier -> drain
    typedef enum logic [1:0] {
        rx_idle    = 2'h0,
        rx_carrier = 2'h1,
        rx_drain   = 2'h3
    } rmpi_rx_state_t;

endpackage

/* File: test/rmii_phy_mac_side_interface_tb_top.sv */
`timescale 1ns/1ps

// ========================================
// bench: phy end and mac end joined across the link
module rmii_phy_mac_side_interface_tb_top;
    import rmpi_pkg::*;

    localparam int DIV = 10;

    logic         clock     = 1'b0;
    logic         rst_b     = 1'b0;
    logic         carrier   = 1'b0;
    logic         code_bit  = 1'b1;
    logic         data_bit  = 1'b0;
    logic         data_stb  = 1'b0;
    logic         rx_err    = 1'b0;
    logic         tx_valid  = 1'b0;
    rmpi_nibble_t tx_nibble = 4'h0;
    logic         an_en, f_spd, f_fd, a_spd, a_fd;
    logic         speed, fd, cs, col, l_en, l_stb, tx_ready, rx_stb, rx_frame, crs, mcol;
    rmpi_dibit_t  l_dib;
    rmpi_nibble_t rx_nib;
    rmpi_dibit_t  exp_tx[$];
    rmpi_nibble_t exp_rx[$];
    int           n_errors        = 0;
    int           samples_checked = 0;
    int           seed            = 46;

    rmpi_if link();

    // system clock and free running reference clock
    always #5 clock = ~clock;
    initial begin
        link.ref_clk = 1'b0;
        #3;
        forever #62.5 link.ref_clk = ~link.ref_clk;
    end

    // line code: alternating while carrier is on, all ones otherwise
    always @(negedge clock) code_bit <= carrier ? ~code_bit : 1'b1;

    rmpi_phy_end #(.DIV_10M(DIV)) i_rmpi_phy_end (
        .clock_i(clock), .rst_b_i(rst_b), .link(link),
        .an_enable_i(an_en), .force_speed_100_i(f_spd), .force_full_duplex_i(f_fd),
        .an_speed_100_i(a_spd), .an_full_duplex_i(a_fd), .squelch_pass_i(carrier),
        .code_bit_i(code_bit), .code_stb_i(1'b1), .data_bit_i(data_bit),
        .data_stb_i(data_stb), .rx_err_i(rx_err), .speed_100_o(speed),
        .full_duplex_o(fd), .carrier_sense_o(cs), .collision_o(col),
        .line_tx_en_o(l_en), .line_tx_dibit_o(l_dib), .line_tx_stb_o(l_stb)
    );

    rmpi_mac_end #(.DIV_10M(DIV)) i_rmpi_mac_end (
        .clock_i(clock), .rst_b_i(rst_b), .link(link), .speed_100_i(speed),
        .full_duplex_i(fd), .tx_valid_i(tx_valid), .tx_nibble_i(tx_nibble),
        .tx_ready_o(tx_ready), .rx_nibble_o(rx_nib), .rx_nibble_stb_o(rx_stb),
        .rx_frame_o(rx_frame), .crs_o(crs), .col_o(mcol)
    );

    rmpi_link_chk #(.DIV_10M(DIV)) i_rmpi_link_chk (
        .clock_i(clock), .rst_b_i(rst_b), .ref_clk(link.ref_clk), .txen(link.txen),
        .txd(link.txd), .rxd(link.rxd), .crs_dv(link.crs_dv), .rxer(link.rxer),
        .speed_100_o(speed)
    );

    // ========================================
    // report helpers
    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic stop();
        n_errors++;
        summarize();
    endtask

    // ========================================
    // drivers
    // offer nibbles to the mac end and note the dibits due on the line
    task automatic send_tx(input int n);
        int w;
        for (int i = 0; i < n; i++) begin
            tx_valid = 1'b1;
            tx_nibble = 4'($random(seed));
            exp_tx.push_back(tx_nibble[1:0]);
            exp_tx.push_back(tx_nibble[3:2]);
            w = 0;
            // ready looked at mid-cycle, taken at the next rising edge
            while (tx_ready !== 1'b1 && w < 4000) begin
                @(negedge clock);
                w++;
            end
            if (w >= 4000) stop();
            @(negedge clock);
        end
        tx_valid = 1'b0;
    endtask

    // raise carrier, feed decoded bits low first, then drop carrier
    task automatic send_rx(input int n, input int g);
        rmpi_nibble_t nib;
        carrier = 1'b1;
        repeat (n ? 20 : 200) @(negedge clock);
        check("carrier start", 4'h4, {link.crs_dv, link.rxd});
        for (int i = 0; i < n; i++) begin
            nib = i ? 4'($random(seed)) : 4'h5;
            exp_rx.push_back(nib);
            for (int b = 0; b < 4; b++) begin
                {data_bit, data_stb, rx_err} = {nib[b], 1'b1, 1'($random(seed))};
                @(negedge clock);
                data_stb = 1'b0;
                repeat (g - 1) @(negedge clock);
            end
        end
        carrier = 1'b0;
    endtask

    // wait until both ends are quiet and every note is used
    task automatic settle();
        int w = 0;
        while (w < 5000 && (exp_tx.size() + exp_rx.size() != 0
                            || rx_frame !== 1'b0 || link.crs_dv !== 1'b0)) begin
            @(negedge clock);
            w++;
        end
        if (w >= 5000) stop();
        repeat (200) @(negedge clock);
    endtask

    // one forced mode: transmit, then receive on top of it
    task automatic run(input logic sp, input logic dup);
        int t = sp ? 100 : 300;
        {an_en, f_spd, f_fd} = {1'b0, sp, dup};
        repeat (5) @(negedge clock);
        fork
            send_tx(sp ? 16 : 4);
            begin
                repeat (t) @(negedge clock);
                check("tx sense", !dup, cs);
                send_rx(4, sp ? 5 : 50);
            end
            begin
                repeat (t + 30) @(negedge clock);
                check("collision", {!dup, !dup}, {col, mcol});
                check("rx sense", 2'b11, {cs, crs});
            end
        join
        settle();
    endtask

    // score observed dibits and nibbles against the oldest note
    always @(negedge clock) begin
        if (rst_b && l_stb === 1'b1 && l_en === 1'b1)
            check("line dibit", exp_tx.size() ? exp_tx.pop_front() : 4'hx, l_dib);
        if (rst_b && rx_stb === 1'b1)
            check("rx nibble", exp_rx.size() ? exp_rx.pop_front() : 4'hx, rx_nib);
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clock);
        stop();
    end

    // ========================================
    // main sequence
    initial begin
        {an_en, f_spd, f_fd, a_spd, a_fd} = 5'h0;
        repeat (8) @(negedge clock);
        rst_b = 1'b1;
        repeat (3) @(negedge clock);
        for (int i = 0; i < 16; i++) begin
            {an_en, f_spd, f_fd, a_spd, a_fd} = {i[0], 4'($random(seed))};
            repeat (3) @(negedge clock);
            check("mode", an_en ? {a_spd, a_fd} : {f_spd, f_fd}, {speed, fd});
        end
        for (int i = 0; i < 4; i++) run(i[1], i[0]);
        {an_en, f_spd, f_fd} = 3'b010;
        send_rx(0, 5);
        settle();
        check("pending", 4'h0, 4'(exp_tx.size() + exp_rx.size()));
        summarize();
    end
endmodule

/* File: test/rmpi_link_chk.sv */
`timescale 1ns/1ps

// ========================================
// link checker: slot timing on the shared reference clock
module rmpi_link_chk #(
    parameter int DIV_10M = 10
) (
    input wire logic                  clock_i,
    input wire logic                  rst_b_i,
    input wire logic                  ref_clk,
    input wire logic                  txen,
    input wire rmpi_pkg::rmpi_dibit_t txd,
    input wire rmpi_pkg::rmpi_dibit_t rxd,
    input wire logic                  crs_dv,
    input wire logic                  rxer,
    input wire logic                  speed_100_o
);
    import rmpi_pkg::*;

    localparam int HOLD_100 = 12;
    localparam int HOLD_10  = DIV_10M * 25 / 2 - 1;
    localparam int QUIET    = 200;

    int tx_gap;
    int rx_gap;
    int low_cnt;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    // clocks since the last change of each data pair
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            tx_gap <= QUIET;
            rx_gap <= QUIET;
        end else begin
            tx_gap <= (txd != $past(txd)) ? 1 : tx_gap + 1;
            rx_gap <= (rxd != $past(rxd)) ? 1 : rx_gap + 1;
        end
    end

    // clocks spent with crs_dv low, saturating
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            low_cnt <= QUIET;
        end else begin
            low_cnt <= crs_dv ? 0 : ((low_cnt < QUIET) ? low_cnt + 1 : QUIET);
        end
    end

    a_rxd_ref_edge: assert property ($changed(rxd) |-> ref_clk)
        else $error("rxd moved away from a reference rise");
    a_crs_drop_edge: assert property ($fell(crs_dv) |-> ref_clk)
        else $error("crs_dv fell away from a reference rise");
    a_txen_ref_edge: assert property ($changed(txen) |-> ref_clk)
        else $error("txen moved away from a reference rise");
    a_rxer_ref_edge: assert property ($changed(rxer) |-> ref_clk)
        else $error("rxer moved away from a reference rise");
    a_rx_zero_start: assert property ($rose(crs_dv) && low_cnt >= QUIET |-> rxd == 2'h0)
        else $error("rxd not zero when carrier rose");
    a_tx_hold_fast: assert property ($changed(txd) && speed_100_o |-> tx_gap >= HOLD_100)
        else $error("txd held shorter than one reference period");
    a_tx_hold_slow: assert property ($changed(txd) && !speed_100_o |-> tx_gap >= HOLD_10)
        else $error("txd held shorter than ten reference periods");
    a_rx_hold_fast: assert property ($changed(rxd) && speed_100_o |-> rx_gap >= HOLD_100)
        else $error("rxd held shorter than one reference period");
    a_rx_hold_slow: assert property ($changed(rxd) && !speed_100_o |-> rx_gap >= HOLD_10)
        else $error("rxd held shorter than ten reference periods");

    // main scenarios seen
    c_frame_start: cover property ($rose(crs_dv));
    c_drain_toggle: cover property ($fell(crs_dv) ##[1:14] $rose(crs_dv));
    c_tx_start: cover property ($rose(txen));
endmodule
